// ---- hdl/scs_pkg.sv ----
// Constants, encodings and helpers for the strap and configuration-select block.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register port.
package scs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned RST_MIN_NS = 1000;
  localparam int unsigned RST_MIN_CYC_I = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W = 8;
  localparam logic [RST_CNT_W-1:0] RST_MIN_CYC = RST_CNT_W'(RST_MIN_CYC_I);

  localparam int unsigned SYNC_W = 6;

  localparam logic [1:0] SEL_DEFAULT = 2'h0;
  localparam logic [1:0] SEL_SMBUS = 2'h1;
  localparam logic [1:0] SEL_DEFAULT_BUS = 2'h2;
  localparam logic [1:0] SEL_EEPROM = 2'h3;

  localparam logic [6:0] SMBUS_SLAVE_ADDR = 7'h2c;

  localparam int unsigned AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL_ADDR = 8'h00;
  localparam logic [AXI_AW-1:0] REG_STATUS_ADDR = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields
  localparam int unsigned CTRL_IND_EN = 0;
  localparam int unsigned CTRL_FP_LO = 1;
  localparam int unsigned CTRL_FP_HI = 2;
  localparam int unsigned CTRL_ACT_LOW = 3;
  localparam int unsigned CTRL_BUS_PWR = 4;
  localparam int unsigned CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h01;

  // Status register fields
  localparam int unsigned ST_METHOD_LO = 0;
  localparam int unsigned ST_FP_LO = 2;
  localparam int unsigned ST_ACT_LOW = 4;
  localparam int unsigned ST_SELF_PWR = 5;
  localparam int unsigned ST_ACTIVE = 6;
  localparam int unsigned ST_LOADED = 7;
  localparam int unsigned ST_PAIR_LO = 8;

  // 00 all removable, 01 port 1 fixed, 1x ports 1 and 2 fixed
  function automatic logic [1:0] fixed_decode(input logic [1:0] pair);
    logic [1:0] m;
    m = 2'h0;
    if (pair[1])
      m = 2'h3;
    else if (pair[0])
      m = 2'h1;
    return m;
  endfunction

  function automatic logic strap_mode(input logic [1:0] method);
    return (method == SEL_DEFAULT) || (method == SEL_DEFAULT_BUS);
  endfunction

endpackage

// ---- hdl/scs_strap_if.sv ----
// Latched strap values passed from the capture module to the top.
// Assumes one producer (latch) and one consumer (top).
`timescale 1ns/10ps
interface scs_strap_if;
  logic loaded;
  logic [1:0] method;
  logic [1:0] pair;
  modport latch (output loaded, output method, output pair);
  modport user (input loaded, input method, input pair);
endinterface // scs_strap_if

// ---- hdl/scs_sync.sv ----
// Two-flop synchroniser for a bundle of independent pin levels.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/10ps
module scs_sync #(
  parameter int unsigned W = 1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule // scs_sync

// ---- hdl/scs_strap_latch.sv ----
// Captures the configuration-select and fixed-port straps on one pulse.
// Assumes capture is a single-cycle pulse at reset release; cleared only by sys_rst.
`timescale 1ns/10ps
module scs_strap_latch (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic capture,
  input wire logic [1:0] method_pin,
  input wire logic [1:0] pair_pin,
  scs_strap_if.latch st
);
  logic loaded_q;
  logic loaded_d;
  logic [1:0] method_q;
  logic [1:0] method_d;
  logic [1:0] pair_q;
  logic [1:0] pair_d;

  // Pins are ignored outside the capture pulse, since they serve other uses later
  always_comb
  begin
    loaded_d = loaded_q;
    method_d = method_q;
    pair_d = pair_q;
    if (capture)
    begin
      loaded_d = 1'b1;
      method_d = method_pin;
      pair_d = pair_pin;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      loaded_q <= 1'b0;
      method_q <= scs_pkg::SEL_DEFAULT;
      pair_q <= 2'h0;
    end
    else
    begin
      loaded_q <= loaded_d;
      method_q <= method_d;
      pair_q <= pair_d;
    end
  end

  assign st.loaded = loaded_q;
  assign st.method = method_q;
  assign st.pair = pair_q;

  property p_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    !capture |=> (method_q == $past(method_q)) && (pair_q == $past(pair_q));
  endproperty
  a_hold: assert property (p_hold) else $error("latched straps changed without capture");
endmodule // scs_strap_latch

// ---- hdl/scs_top.sv ----
// Strap sampling, configuration-method select, activity indicator and self-power sense.
// Assumes pins are asynchronous to sys_clk; hub status inputs are on sys_clk.
`timescale 1ns/10ps
module scs_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_n_pin,
  input wire logic por_ok,
  input wire logic config_method_sel_lo,
  input wire logic config_method_sel_hi,
  input wire logic fixed_port_strap_hi,
  input wire logic act_pin_i,
  output logic act_pin_o,
  output logic act_pin_oe,
  input wire logic hub_configured,
  input wire logic hub_suspended,
  output logic logic_rst,
  output logic strap_enabled,
  output logic smbus_slave_en,
  output logic eeprom_load_en,
  output logic [6:0] smbus_slave_addr,
  output logic [1:0] fixed_ports,
  output logic self_powered,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [scs_pkg::SYNC_W-1:0] sync_out;
  logic rstn_s;
  logic por_s;
  logic [1:0] sel_s;
  logic [1:0] pair_s;
  logic rel;
  logic capture;
  scs_strap_if st ();

  scs_sync #(.W(scs_pkg::SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din({reset_n_pin, por_ok, config_method_sel_hi, config_method_sel_lo,
          fixed_port_strap_hi, act_pin_i}),
    .dout(sync_out)
  );

  assign {rstn_s, por_s, sel_s, pair_s} = sync_out;
  assign rel = rstn_s & por_s;

  // Reset release and minimum reset length
  logic rel_q;
  logic rel_d;
  logic [scs_pkg::RST_CNT_W-1:0] rcnt_q;
  logic [scs_pkg::RST_CNT_W-1:0] rcnt_d;
  logic lrst_q;
  logic lrst_d;

  assign capture = rel & ~rel_q;

  always_comb
  begin
    rel_d = rel;
    rcnt_d = rcnt_q;
    if (!rel)
      rcnt_d = '0;
    else if (rcnt_q != scs_pkg::RST_MIN_CYC)
      rcnt_d = rcnt_q + 1'b1;
    // Stretch so the core always sees a full minimum reset, even from a glitch
    lrst_d = !rel || (rcnt_q != scs_pkg::RST_MIN_CYC);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rel_q <= 1'b0;
      rcnt_q <= '0;
      lrst_q <= 1'b1;
    end
    else
    begin
      rel_q <= rel_d;
      rcnt_q <= rcnt_d;
      lrst_q <= lrst_d;
    end
  end

  // The shared pin is tristated through reset, so it reads the strap at release
  scs_strap_latch u_latch (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .capture(capture),
    .method_pin(sel_s),
    .pair_pin(pair_s),
    .st(st)
  );

  // Control register, reset with the core logic
  logic [scs_pkg::CTRL_W-1:0] ctrl_q;
  logic [scs_pkg::CTRL_W-1:0] ctrl_d;
  logic wr_ctrl;
  logic [7:0] wr_byte;

  // Derived settings and registered outputs
  logic smode;
  logic [1:0] fp_sel;
  logic low_sel;
  logic bus_force;
  logic act_q, act_d, oe_q, oe_d, lowq_q, lowq_d;
  logic strap_q, strap_d, smb_q, smb_d, eep_q, eep_d, selfp_q, selfp_d;
  logic [1:0] fp_q;
  logic [1:0] fp_d;
  logic [6:0] addr_q;
  logic [6:0] addr_d;

  always_comb
  begin
    smode = scs_pkg::strap_mode(st.method);
    fp_sel = smode ? scs_pkg::fixed_decode(st.pair)
                   : {ctrl_q[scs_pkg::CTRL_FP_HI], ctrl_q[scs_pkg::CTRL_FP_LO]};
    low_sel = smode ? st.pair[0] : ctrl_q[scs_pkg::CTRL_ACT_LOW];
    bus_force = (st.method == scs_pkg::SEL_DEFAULT_BUS)
             || (!smode && ctrl_q[scs_pkg::CTRL_BUS_PWR]);
    strap_d = 1'b0;
    smb_d = 1'b0;
    eep_d = 1'b0;
    addr_d = '0;
    fp_d = '0;
    lowq_d = 1'b0;
    selfp_d = 1'b0;
    act_d = 1'b0;
    oe_d = 1'b0;
    if (!lrst_q)
    begin
      strap_d = smode;
      smb_d = (st.method == scs_pkg::SEL_SMBUS);
      eep_d = (st.method == scs_pkg::SEL_EEPROM);
      addr_d = smb_d ? scs_pkg::SMBUS_SLAVE_ADDR : 7'h00;
      fp_d = fp_sel;
      lowq_d = low_sel;
      oe_d = ctrl_q[scs_pkg::CTRL_IND_EN];
      // Pin is sensed only while we are not driving it
      selfp_d = oe_q ? selfp_q : (pair_s[0] && !bus_force);
      act_d = (hub_configured && !hub_suspended) ^ low_sel;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      strap_q <= 1'b0;
      smb_q <= 1'b0;
      eep_q <= 1'b0;
      addr_q <= '0;
      fp_q <= '0;
      lowq_q <= 1'b0;
      selfp_q <= 1'b0;
      act_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      strap_q <= strap_d;
      smb_q <= smb_d;
      eep_q <= eep_d;
      addr_q <= addr_d;
      fp_q <= fp_d;
      lowq_q <= lowq_d;
      selfp_q <= selfp_d;
      act_q <= act_d;
      oe_q <= oe_d;
    end
  end

  // AXI4-Lite slave; bus handshake survives a pin reset so no beat is dropped
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic [7:0] waddr_q, waddr_d;
  logic [7:0] wdat_q, wdat_d;
  logic wstb_q, wstb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status;

  always_comb
  begin
    status = '0;
    status[scs_pkg::ST_METHOD_LO +: 2] = st.method;
    status[scs_pkg::ST_FP_LO +: 2] = fp_q;
    status[scs_pkg::ST_ACT_LOW] = lowq_q;
    status[scs_pkg::ST_SELF_PWR] = selfp_q;
    status[scs_pkg::ST_ACTIVE] = act_q ^ lowq_q;
    status[scs_pkg::ST_LOADED] = st.loaded;
    status[scs_pkg::ST_PAIR_LO +: 2] = st.pair;
  end

  always_comb
  begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    waddr_d = waddr_q;
    wdat_d = wdat_q;
    wstb_d = wstb_q;
    bv_d = bv_q;
    bresp_d = bresp_q;
    wr_ctrl = 1'b0;
    wr_byte = wdat_q;
    if (s_axi_awvalid && awr_q)
    begin
      aw_got_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_q)
    begin
      w_got_d = 1'b1;
      wdat_d = s_axi_wdata[7:0];
      wstb_d = s_axi_wstrb[0];
    end
    if (aw_got_q && w_got_q && !bv_q)
    begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bv_d = 1'b1;
      if (waddr_q == scs_pkg::REG_CTRL_ADDR)
      begin
        wr_ctrl = wstb_q;
        bresp_d = scs_pkg::RESP_OKAY;
      end
      else if (waddr_q == scs_pkg::REG_STATUS_ADDR)
        bresp_d = scs_pkg::RESP_OKAY;
      else
        bresp_d = scs_pkg::RESP_SLVERR;
    end
    else if (bv_q && s_axi_bready)
      bv_d = 1'b0;
    awr_d = !aw_got_d && !bv_d;
    wr_d = !w_got_d && !bv_d;
    arr_d = arr_q || !rv_q;
    rv_d = rv_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arr_q)
    begin
      arr_d = 1'b0;
      rv_d = 1'b1;
      rresp_d = scs_pkg::RESP_OKAY;
      rdata_d = '0;
      if (s_axi_araddr == scs_pkg::REG_CTRL_ADDR)
        rdata_d = 32'(ctrl_q);
      else if (s_axi_araddr == scs_pkg::REG_STATUS_ADDR)
        rdata_d = status;
      else
        rresp_d = scs_pkg::RESP_SLVERR;
    end
    else if (rv_q && s_axi_rready)
    begin
      rv_d = 1'b0;
      arr_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= '0;
      wdat_q <= '0;
      wstb_q <= 1'b0;
      bv_q <= 1'b0;
      bresp_q <= scs_pkg::RESP_OKAY;
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      arr_q <= 1'b0;
      rv_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= scs_pkg::RESP_OKAY;
    end
    else
    begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      waddr_q <= waddr_d;
      wdat_q <= wdat_d;
      wstb_q <= wstb_d;
      bv_q <= bv_d;
      bresp_q <= bresp_d;
      awr_q <= awr_d;
      wr_q <= wr_d;
      arr_q <= arr_d;
      rv_q <= rv_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = wr_byte[scs_pkg::CTRL_W-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || lrst_q)
      ctrl_q <= scs_pkg::CTRL_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  assign act_pin_o = act_q;
  assign act_pin_oe = oe_q;
  assign logic_rst = lrst_q;
  assign strap_enabled = strap_q;
  assign smbus_slave_en = smb_q;
  assign eeprom_load_en = eep_q;
  assign smbus_slave_addr = addr_q;
  assign fixed_ports = fp_q;
  assign self_powered = selfp_q;
  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  property p_rst_low;
    @(posedge sys_clk) disable iff (sys_rst)
    !rstn_s |=> lrst_q ##1 (lrst_q && !act_pin_oe);
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("core left reset while pin low");

  property p_por;
    @(posedge sys_clk) disable iff (sys_rst)
    !por_s |=> lrst_q;
  endproperty
  a_por: assert property (p_por) else $error("core left reset before power-on release");

  property p_act;
    @(posedge sys_clk) disable iff (sys_rst)
    !lrst_q |=> act_pin_o == (($past(hub_configured) && !$past(hub_suspended)) ^ lowq_q);
  endproperty
  a_act: assert property (p_act) else $error("indicator level wrong");

  property p_selfpwr;
    @(posedge sys_clk) disable iff (sys_rst)
    (!lrst_q && !oe_q && st.method == scs_pkg::SEL_DEFAULT) |=> self_powered == $past(pair_s[0]);
  endproperty
  a_selfpwr: assert property (p_selfpwr) else $error("self-power sense wrong");

  property p_fixed;
    @(posedge sys_clk) disable iff (sys_rst)
    (!lrst_q && smode) |=> fixed_ports == {$past(st.pair[1]), |$past(st.pair)};
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed-port decode wrong");

  property p_pol;
    @(posedge sys_clk) disable iff (sys_rst)
    (!lrst_q && smode) |=> lowq_q == $past(st.pair[0]);
  endproperty
  a_pol: assert property (p_pol) else $error("indicator polarity wrong");

  property p_bus;
    @(posedge sys_clk) disable iff (sys_rst)
    (!lrst_q && st.method == scs_pkg::SEL_DEFAULT_BUS) |=> !self_powered && strap_enabled;
  endproperty
  a_bus: assert property (p_bus) else $error("bus-power select not honoured");

  property p_smb;
    @(posedge sys_clk) disable iff (sys_rst)
    (!lrst_q && st.method == scs_pkg::SEL_SMBUS) |=> smbus_slave_en && !eeprom_load_en
      && smbus_slave_addr == scs_pkg::SMBUS_SLAVE_ADDR;
  endproperty
  a_smb: assert property (p_smb) else $error("SMBus mode outputs wrong");

  property p_eep;
    @(posedge sys_clk) disable iff (sys_rst)
    (!lrst_q && st.method == scs_pkg::SEL_EEPROM) |=> eeprom_load_en && !strap_enabled;
  endproperty
  a_eep: assert property (p_eep) else $error("EEPROM mode outputs wrong");

  property p_regs;
    @(posedge sys_clk) disable iff (sys_rst)
    (!lrst_q && !smode) |=>
      fixed_ports == $past({ctrl_q[scs_pkg::CTRL_FP_HI], ctrl_q[scs_pkg::CTRL_FP_LO]});
  endproperty
  a_regs: assert property (p_regs) else $error("straps used in register mode");

  property p_cap;
    @(posedge sys_clk) disable iff (sys_rst)
    capture |=> st.method == $past(sel_s) && st.pair == $past(pair_s);
  endproperty
  a_cap: assert property (p_cap) else $error("selects not captured at release");
endmodule // scs_top

// ---- testbench/scs_board_model.sv ----
// Board model: strap resistors, reset source and the shared indicator pin.
// Assumes the bench steers it just after rising edges of sys_clk.
`timescale 1ns/10ps
module scs_board_model (
  input wire logic sys_clk,
  input wire logic rst_req,
  input wire logic por_good,
  input wire logic [1:0] sel_lvl,
  input wire logic hi_lvl,
  input wire logic pin_lvl,
  input wire logic bus_busy,
  input wire logic act_pin_o,
  input wire logic act_pin_oe,
  output logic reset_n_pin,
  output logic por_ok,
  output logic config_method_sel_lo,
  output logic config_method_sel_hi,
  output logic fixed_port_strap_hi,
  output logic act_pin_i
);
  // 1 us at 5 ns a cycle; the pin stays low this long after a request ends
  localparam int HOLD_CYC = 200;
  int hold_q = 0;
  logic tgl_q = 1'b0;

  always_ff @(posedge sys_clk)
  begin
    tgl_q <= ~tgl_q;
    if (rst_req)
      hold_q <= HOLD_CYC;
    else if (hold_q > 0)
      hold_q <= hold_q - 1;
  end

  assign reset_n_pin = !(rst_req || hold_q > 0);
  assign por_ok = por_good;
  // Once the pins serve as a serial bus they move every cycle
  assign config_method_sel_lo = bus_busy ? tgl_q : sel_lvl[0];
  assign config_method_sel_hi = bus_busy ? ~tgl_q : sel_lvl[1];
  assign fixed_port_strap_hi = bus_busy ? tgl_q : hi_lvl;
  // Resistor level shows only while the device does not drive the pin
  assign act_pin_i = act_pin_oe ? act_pin_o : pin_lvl;
endmodule // scs_board_model

// ---- testbench/strap_config_select_tb.sv ----
// Self-checking bench for the strap and configuration-select block.
// Assumes scs_board_model on the pins and registers over AXI4-Lite.
`timescale 1ns/10ps
module strap_config_select_tb;
  logic sys_clk, sys_rst, rst_req, por_good, hi_lvl, pin_lvl, bus_busy;
  logic [1:0] sel_lvl;
  logic reset_n_pin, por_ok, config_method_sel_lo, config_method_sel_hi, fixed_port_strap_hi;
  logic act_pin_i, act_pin_o, act_pin_oe, hub_configured, hub_suspended, logic_rst;
  logic strap_enabled, smbus_slave_en, eeprom_load_en, self_powered;
  logic [6:0] smbus_slave_addr;
  logic [1:0] fixed_ports, s_axi_bresp, s_axi_rresp;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_total = 0;
  int num_checks = 0;

  scs_top dut (.sys_clk, .sys_rst, .reset_n_pin, .por_ok, .config_method_sel_lo,
    .config_method_sel_hi, .fixed_port_strap_hi, .act_pin_i, .act_pin_o, .act_pin_oe,
    .hub_configured, .hub_suspended, .logic_rst, .strap_enabled, .smbus_slave_en,
    .eeprom_load_en, .smbus_slave_addr, .fixed_ports, .self_powered, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  scs_board_model board (.sys_clk, .rst_req, .por_good, .sel_lvl, .hi_lvl, .pin_lvl,
    .bus_busy, .act_pin_o, .act_pin_oe, .reset_n_pin, .por_ok, .config_method_sel_lo,
    .config_method_sel_hi, .fixed_port_strap_hi, .act_pin_i);

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Address and data offered together; each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        r = s_axi_bresp;
        done = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        done = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  // Short pin pulse; the board stretches it, then straps start to move
  task automatic do_reset(input int m, input int p);
    @(posedge sys_clk);
    bus_busy <= 1'b0;
    sel_lvl <= 2'(m);
    hi_lvl <= p[1];
    pin_lvl <= p[0];
    rst_req <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst_req <= 1'b0;
    repeat (150) @(posedge sys_clk);
    chk("logic_rst", 1, logic_rst);
    while (logic_rst !== 1'b0)
      @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    bus_busy <= 1'b1;
  endtask

  task automatic check_all(input int m, input int p, input logic [4:0] c);
    logic sm, al;
    logic [1:0] fp, r;
    logic [31:0] d, e;
    sm = (m == 0) || (m == 2);
    fp = sm ? ((p == 0) ? 2'h0 : ((p == 1) ? 2'h1 : 2'h3)) : c[2:1];
    al = sm ? p[0] : c[3];
    chk("strap_enabled", sm, strap_enabled);
    chk("smbus_slave_en", m == 1, smbus_slave_en);
    chk("smbus_slave_addr", (m == 1) ? 32'h2c : 32'h0, smbus_slave_addr);
    chk("eeprom_load_en", m == 3, eeprom_load_en);
    chk("fixed_ports", fp, fixed_ports);
    chk("act_pin_oe", c[0], act_pin_oe);
    if (c[0])
      chk("act_pin_o", (hub_configured & ~hub_suspended) ^ al, act_pin_o);
    else
      chk("self_powered", pin_lvl & (m != 2) & ~(~sm & c[4]), self_powered);
    axi_rd(8'h04, d, r);
    e = {22'h0, 2'(p), 1'b1, hub_configured & ~hub_suspended, 1'b0, al, fp, 2'(m)};
    chk("status", e, d & 32'h3df);
  endtask

  initial
  begin
    logic [31:0] d;
    logic [4:0] c;
    logic [1:0] r;
    sys_rst = 1'b1;
    seed = 32'h52c6;
    sel_lvl = 2'h0;
    {rst_req, por_good, hi_lvl, pin_lvl, bus_busy, hub_configured, hub_suspended} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (300) @(posedge sys_clk);
    chk("logic_rst", 1, logic_rst);
    por_good <= 1'b1;
    c = 5'h01;
    for (int m = 0; m < 4; m++)
      for (int p = 0; p < 4; p++)
      begin
        do_reset(m, p);
        axi_rd(8'h00, d, r);
        chk("ctrl", 32'h01, d);
        for (int h = 0; h < 4; h++)
        begin
          hub_configured <= h[0];
          hub_suspended <= h[1];
          repeat (3) @(posedge sys_clk);
          check_all(m, p, 5'h01);
        end
        for (int k = 0; k < 2; k++)
        begin
          d = rnd();
          c = d[4:0] & ((k == 1) ? 5'h1e : 5'h1f);
          pin_lvl <= d[7];
          hub_configured <= d[8];
          hub_suspended <= d[9];
          axi_wr(8'h00, {d[31:5], c}, r);
          chk("bresp", 0, r);
          axi_rd(8'h00, d, r);
          chk("ctrl", c, d);
          repeat (6) @(posedge sys_clk);
          check_all(m, p, c);
        end
      end
    axi_rd(8'h08, d, r);
    chk("rresp", 2, r);
    chk("rdata", 0, d);
    axi_wr(8'h0c, 32'h1f, r);
    chk("bresp", 2, r);
    axi_wr(8'h04, 32'hffffffff, r);
    chk("bresp", 0, r);
    check_all(3, 3, c);
    summarize();
  end

  // Whole run needs about 8k cycles; this cuts a hang short
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    summarize();
  end
endmodule // strap_config_select_tb
